// [rtl/smpd_pkg.sv]
package smpd_pkg;

   localparam int        CLK_MHZ = 250;

   // Register byte offsets.
   localparam logic [7:0] OFF_CTL     = 8'h00;
   localparam logic [7:0] OFF_CS      = 8'h04;
   localparam logic [7:0] OFF_BDCTL   = 8'h08;
   localparam logic [7:0] OFF_INT_ST  = 8'h0c;
   localparam logic [7:0] OFF_INT_EN  = 8'h10;
   localparam logic [7:0] OFF_INT_CLR = 8'h14;

   // Power control register fields.
   localparam int CTL_LVTH_LO = 0;
   localparam int CTL_LVEN    = 4;
   localparam int CTL_OVTH_LO = 5;
   localparam int CTL_OVEN    = 7;
   localparam int CTL_STBMOD  = 8;
   localparam int CTL_LDOLP   = 9;
   localparam int CTL_SLPDEEP = 10;

   // Status register fields.
   localparam int CS_LVFLAG = 0;
   localparam int CS_OVFLAG = 1;
   localparam int CS_STBF = 2;

   // Backup domain control fields.
   localparam int BD_RTCSRC_LO = 0;
   localparam int BD_RTCEN     = 2;
   localparam int BD_WKEN      = 3;
   localparam int BD_SWRST     = 16;

   // Interrupt status bits.
   localparam int IRQ_LOWV  = 0;
   localparam int IRQ_OVERV = 1;
   localparam int IRQ_WAKE = 2;
   localparam int IRQ_W    = 3;

   localparam logic [31:0] CTL_RST   = 32'h0000_0000;
   localparam logic [31:0] BDCTL_RST = 32'h0000_0000;

   localparam int          HXT_DIV   = 128;
   localparam logic [6:0]  HXT_DIV_M = 7'h7f;

   localparam logic [1:0]  RTC_SLOWRC = 2'h1;
   localparam logic [1:0]  RTC_LSXT   = 2'h2;
   localparam logic [1:0]  RTC_HXT128 = 2'h3;

   localparam logic [1:0]  REG_FULL = 2'h0;
   localparam logic [1:0]  REG_LOWP = 2'h1;
   localparam logic [1:0]  REG_OFF  = 2'h2;

   // Core-domain reset sequence length after power-up, given in ns and converted to cycles.
   localparam int          CORE_RST_NS  = 64;
   localparam int          CORE_RST_CYC = (CORE_RST_NS * CLK_MHZ + 999) / 1000;
   localparam logic [4:0]  CORE_RST_N   = 5'(CORE_RST_CYC);

   localparam logic [1:0]  HTRANS_NONSEQ = 2'h2;

   typedef enum logic [1:0] {
      PM_RUN   = 2'b00,
      PM_SLEEP = 2'b01,
      PM_DEEP  = 2'b11,
      PM_STBY  = 2'b10
   } smpd_pm_e;

   typedef struct packed {
      logic       sel;
      logic [1:0] htrans;
      logic [7:0] haddr;
      logic       hwrite;
      logic [2:0] hsize;
   } smpd_ahb_s;

   typedef struct packed {
      logic low;
      logic over;
   } smpd_det_s;

endpackage

// [rtl/smpd_sync.sv]
`timescale 1ns/1ps
module smpd_sync #(
   parameter int W = 2
) (
   input  wire logic         clk,
   input  wire logic         rst_n,
   input  wire logic [W-1:0] din,
   output logic      [W-1:0] dout
);
   logic [W-1:0] meta_q;

   // The first stage feeds only the second stage, never any logic.
   genvar i;
   generate
      for (i = 0; i < W; i++) begin : g_bit
         always_ff @(posedge clk or negedge rst_n) begin
            if (!rst_n) begin
               meta_q[i] <= 1'b0;
               dout[i]   <= 1'b0;
            end else begin
               meta_q[i] <= din[i];
               dout[i]   <= meta_q[i];
            end
         end
      end
   endgenerate
endmodule

// [rtl/smpd_top.sv]
`timescale 1ns/1ps
// Operation
// - Enabled low detector uses three-bit threshold
// - Low-voltage flag shows current supply state
// - Low detector output drives event line 16
// - Over detector active only when enabled
// - Over-voltage flag shows current supply state
// - Over detector output drives event line 24
// - Backup-reset bit applies backup software reset
// - Backup held reset until backup supply up
// - Clock source: slow RC, slow crystal, fast/128
// - RTC time match wakes from power save
// - Brown-out resets chip except backup domain
// - Power-on/down reset resets whole chip
// - Core power-up runs core reset sequence
// - Configure mode, then wait instruction enters it
// - Regulator on after reset, follows mode
module smpd_top (
   input  wire logic        CLOCK,
   input  wire logic        NRST,
   input  wire logic        HSEL,
   input  wire logic [1:0]  HTRANS,
   input  wire logic [7:0]  HADDR,
   input  wire logic        HWRITE,
   input  wire logic [2:0]  HSIZE,
   input  wire logic [31:0] HWDATA,
   input  wire logic        HREADY,
   output logic      [31:0] HRDATA,
   output logic             HREADYOUT,
   output logic             HRESP,
   input  wire logic        LOWV_CMP,
   input  wire logic        OVERV_CMP,
   output logic      [2:0]  LOWV_THRESH,
   output logic      [1:0]  OVERV_THRESH,
   output logic             LOWV_ANALOG_EN,
   output logic             OVERV_ANALOG_EN,
   output logic             EVT_LINE16,
   output logic             EVT_LINE24,
   input  wire logic        PWRON_N,
   input  wire logic        BROWN_N,
   input  wire logic        BAK_SUPPLY_OK,
   input  wire logic        CORE_PWR_OK,
   output logic             BACKUP_RST_N,
   output logic             SYS_RST_N,
   output logic             CORE_RST_N,
   input  wire logic        SLOWRC_CLK,
   input  wire logic        LSXT_CLK,
   input  wire logic        HSXT_CLK,
   output logic             RTC_CLK,
   input  wire logic        RTC_MATCH,
   input  wire logic        WAIT_IRQ,
   input  wire logic        WAIT_EVT,
   output logic      [1:0]  PM_MODE,
   output logic      [1:0]  REG_MODE,
   output logic             WAKEUP,
   output logic             IRQ
);
   smpd_pkg::smpd_ahb_s  ap_q;
   smpd_pkg::smpd_det_s  det_raw;
   smpd_pkg::smpd_det_s  det_s;
   smpd_pkg::smpd_det_s  det_prev_q;
   smpd_pkg::smpd_pm_e   pm_q;
   logic [31:0] ctl_q;
   logic [31:0] bd_q;
   logic        stbf_q;
   logic [smpd_pkg::IRQ_W-1:0] ist_q;
   logic [smpd_pkg::IRQ_W-1:0] ien_q;
   logic [smpd_pkg::IRQ_W-1:0] ev;
   logic        wr_ok;
   logic        rd_ok;
   logic [31:0] rdata_d;
   logic        lowv_en;
   logic        overv_en;
   logic [6:0]  hdiv_q;
   logic        hdiv_clk_q;
   logic        rtc_d;
   logic        bkp_sw_q;
   logic [4:0]  core_cnt_q;
   logic        sleep_cmd;
   logic        bad_size;

   assign lowv_en  = ctl_q[smpd_pkg::CTL_LVEN];
   assign overv_en = ctl_q[smpd_pkg::CTL_OVEN];

   // Detector levels are asynchronous to the system clock.
   assign det_raw.low  = LOWV_CMP;
   assign det_raw.over = OVERV_CMP;

   smpd_sync #(.W(2)) u_det_sync (
      .clk   (CLOCK),
      .rst_n (NRST),
      .din   (det_raw),
      .dout  (det_s)
   );

   // AHB-Lite address phase capture; the slave is always zero wait-state.
   always_ff @(posedge CLOCK or negedge NRST) begin
      if (!NRST) begin
         ap_q <= '0;
      end else if (HREADY) begin
         ap_q.sel    <= HSEL && (HTRANS == smpd_pkg::HTRANS_NONSEQ);
         ap_q.htrans <= HTRANS;
         ap_q.haddr  <= HADDR;
         ap_q.hwrite <= HWRITE;
         ap_q.hsize  <= HSIZE;
      end
   end

   assign bad_size = 1'b0;
   assign wr_ok = ap_q.sel && ap_q.hwrite && !bad_size;
   assign rd_ok = HSEL && (HTRANS == smpd_pkg::HTRANS_NONSEQ) && HREADY && !HWRITE;

   always_ff @(posedge CLOCK or negedge NRST) begin
      if (!NRST) begin
         HREADYOUT <= 1'b1;
         HRESP     <= 1'b0;
      end else begin
         HREADYOUT <= 1'b1;
         HRESP     <= 1'b0;
      end
   end

   // Control register: thresholds, detector enables and mode bits.
   always_ff @(posedge CLOCK or negedge NRST) begin
      if (!NRST) begin
         ctl_q <= smpd_pkg::CTL_RST;
      end else if (wr_ok && ap_q.haddr == smpd_pkg::OFF_CTL) begin
         ctl_q <= HWDATA;
      end
   end

   // Backup-domain control; the software reset bit also clears the domain's own fields.
   always_ff @(posedge CLOCK or negedge NRST) begin
      if (!NRST) begin
         bd_q <= smpd_pkg::BDCTL_RST;
      end else if (!PWRON_N || !BAK_SUPPLY_OK) begin
         bd_q <= smpd_pkg::BDCTL_RST;
      end else if (wr_ok && ap_q.haddr == smpd_pkg::OFF_BDCTL) begin
         bd_q <= HWDATA;
      end else if (bd_q[smpd_pkg::BD_SWRST]) begin
         bd_q[smpd_pkg::BD_SWRST-1:0] <= '0;
      end
   end

   always_ff @(posedge CLOCK or negedge NRST) begin
      if (!NRST) begin
         bkp_sw_q <= 1'b0;
      end else begin
         bkp_sw_q <= bd_q[smpd_pkg::BD_SWRST];
      end
   end

   // Brown-out does not touch the backup domain; power-on/down and backup supply do.
   always_ff @(posedge CLOCK or negedge NRST) begin
      if (!NRST) begin
         BACKUP_RST_N <= 1'b0;
         SYS_RST_N    <= 1'b0;
      end else begin
         BACKUP_RST_N <= PWRON_N && BAK_SUPPLY_OK && !bkp_sw_q;
         SYS_RST_N    <= PWRON_N && BROWN_N;
      end
   end

   // Core reset stays asserted for a fixed count after the core supply comes good.
   always_ff @(posedge CLOCK or negedge NRST) begin
      if (!NRST) begin
         core_cnt_q <= '0;
         CORE_RST_N <= 1'b0;
      end else if (!CORE_PWR_OK || !PWRON_N || !BROWN_N) begin
         core_cnt_q <= '0;
         CORE_RST_N <= 1'b0;
      end else if (core_cnt_q != smpd_pkg::CORE_RST_N) begin
         core_cnt_q <= core_cnt_q + 5'h01;
         CORE_RST_N <= 1'b0;
      end else begin
         CORE_RST_N <= 1'b1;
      end
   end

   // Detector outputs, gated by their enables.
   always_ff @(posedge CLOCK or negedge NRST) begin
      if (!NRST) begin
         LOWV_ANALOG_EN  <= 1'b0;
         OVERV_ANALOG_EN <= 1'b0;
         LOWV_THRESH     <= '0;
         OVERV_THRESH    <= '0;
         EVT_LINE16      <= 1'b0;
         EVT_LINE24      <= 1'b0;
         det_prev_q      <= '0;
      end else begin
         LOWV_ANALOG_EN  <= lowv_en;
         LOWV_THRESH     <= ctl_q[smpd_pkg::CTL_LVTH_LO +: 3];
         OVERV_ANALOG_EN <= overv_en;
         OVERV_THRESH    <= ctl_q[smpd_pkg::CTL_OVTH_LO +: 2];
         EVT_LINE16      <= lowv_en && det_s.low;
         EVT_LINE24      <= overv_en && det_s.over;
         det_prev_q.low  <= lowv_en && det_s.low;
         det_prev_q.over <= overv_en && det_s.over;
      end
   end

   // RTC clock selection; the divided crystal is a toggle every 64 crystal cycles.
   always_ff @(posedge HSXT_CLK or negedge NRST) begin
      if (!NRST) begin
         hdiv_q     <= '0;
         hdiv_clk_q <= 1'b0;
      end else begin
         hdiv_q <= hdiv_q + 7'h01;
         if (hdiv_q[5:0] == smpd_pkg::HXT_DIV_M[5:0]) begin
            hdiv_clk_q <= ~hdiv_clk_q;
         end
      end
   end

   always_comb begin
      case (bd_q[smpd_pkg::BD_RTCSRC_LO +: 2])
         smpd_pkg::RTC_SLOWRC: rtc_d = SLOWRC_CLK;
         smpd_pkg::RTC_LSXT:   rtc_d = LSXT_CLK;
         smpd_pkg::RTC_HXT128: rtc_d = hdiv_clk_q;
         default:              rtc_d = 1'b0;
      endcase
   end

   always_ff @(posedge CLOCK or negedge NRST) begin
      if (!NRST) begin
         RTC_CLK <= 1'b0;
      end else begin
         RTC_CLK <= bd_q[smpd_pkg::BD_RTCEN] && rtc_d;
      end
   end

   // Power-saving entry and exit.
   assign sleep_cmd = WAIT_IRQ || WAIT_EVT;

   always_ff @(posedge CLOCK or negedge NRST) begin
      if (!NRST) begin
         pm_q   <= smpd_pkg::PM_RUN;
         WAKEUP <= 1'b0;
         stbf_q <= 1'b0;
      end else begin
         WAKEUP <= 1'b0;
         if (pm_q == smpd_pkg::PM_RUN) begin
            if (sleep_cmd) begin
               if (!ctl_q[smpd_pkg::CTL_SLPDEEP]) begin
                  pm_q <= smpd_pkg::PM_SLEEP;
               end else if (ctl_q[smpd_pkg::CTL_STBMOD]) begin
                  pm_q   <= smpd_pkg::PM_STBY;
                  stbf_q <= 1'b1;
               end else begin
                  pm_q <= smpd_pkg::PM_DEEP;
               end
            end
         end else if (RTC_MATCH && bd_q[smpd_pkg::BD_WKEN]) begin
            pm_q   <= smpd_pkg::PM_RUN;
            WAKEUP <= 1'b1;
         end
      end
   end

   always_ff @(posedge CLOCK or negedge NRST) begin
      if (!NRST) begin
         PM_MODE  <= smpd_pkg::PM_RUN;
         REG_MODE <= smpd_pkg::REG_FULL;
      end else begin
         PM_MODE <= pm_q;
         case (pm_q)
            smpd_pkg::PM_STBY: REG_MODE <= smpd_pkg::REG_OFF;
            smpd_pkg::PM_DEEP: REG_MODE <= ctl_q[smpd_pkg::CTL_LDOLP] ?
                                           smpd_pkg::REG_LOWP : smpd_pkg::REG_FULL;
            default:           REG_MODE <= smpd_pkg::REG_FULL;
         endcase
      end
   end

   // Interrupt events: detector edges and the RTC wakeup. Set wins over clear.
   assign ev[smpd_pkg::IRQ_LOWV]  = (lowv_en && det_s.low) != det_prev_q.low;
   assign ev[smpd_pkg::IRQ_OVERV] = (overv_en && det_s.over) != det_prev_q.over;
   assign ev[smpd_pkg::IRQ_WAKE] = RTC_MATCH && bd_q[smpd_pkg::BD_WKEN] &&
                                   (pm_q != smpd_pkg::PM_RUN);

   always_ff @(posedge CLOCK or negedge NRST) begin
      if (!NRST) begin
         ist_q <= '0;
         ien_q <= '0;
      end else begin
         if (wr_ok && ap_q.haddr == smpd_pkg::OFF_INT_EN) begin
            ien_q <= HWDATA[smpd_pkg::IRQ_W-1:0];
         end
         if (wr_ok && ap_q.haddr == smpd_pkg::OFF_INT_CLR) begin
            ist_q <= (ist_q & ~HWDATA[smpd_pkg::IRQ_W-1:0]) | ev;
         end else begin
            ist_q <= ist_q | ev;
         end
      end
   end

   always_ff @(posedge CLOCK or negedge NRST) begin
      if (!NRST) begin
         IRQ <= 1'b0;
      end else begin
         IRQ <= |(ist_q & ien_q);
      end
   end

   // Read data mux; unmapped offsets read as zero.
   always_comb begin
      rdata_d = '0;
      case (HADDR)
         smpd_pkg::OFF_CTL:    rdata_d = ctl_q;
         smpd_pkg::OFF_CS: begin
            rdata_d[smpd_pkg::CS_LVFLAG] = lowv_en && det_s.low;
            rdata_d[smpd_pkg::CS_OVFLAG] = overv_en && det_s.over;
            rdata_d[smpd_pkg::CS_STBF] = stbf_q;
         end
         smpd_pkg::OFF_BDCTL:  rdata_d = bd_q;
         smpd_pkg::OFF_INT_ST: rdata_d[smpd_pkg::IRQ_W-1:0] = ist_q;
         smpd_pkg::OFF_INT_EN: rdata_d[smpd_pkg::IRQ_W-1:0] = ien_q;
         default:              rdata_d = '0;
      endcase
   end

   always_ff @(posedge CLOCK or negedge NRST) begin
      if (!NRST) begin
         HRDATA <= '0;
      end else if (rd_ok) begin
         HRDATA <= rdata_d;
      end
   end

   property p_lvd_line;
      @(posedge CLOCK) disable iff (!NRST)
      !lowv_en |=> !EVT_LINE16;
   endproperty
   a_lvd_line: assert property (p_lvd_line) else $error("Low line high while off.");

   property p_ovd_line;
      @(posedge CLOCK) disable iff (!NRST)
      (overv_en && det_s.over) |=> EVT_LINE24;
   endproperty
   a_ovd_line: assert property (p_ovd_line) else $error("Over line did not follow.");

   property p_bor_keeps_backup;
      @(posedge CLOCK) disable iff (!NRST)
      (!BROWN_N && PWRON_N && BAK_SUPPLY_OK && !bkp_sw_q) |=>
         !SYS_RST_N && BACKUP_RST_N;
   endproperty
   a_bor_keeps_backup: assert property (p_bor_keeps_backup) else $error("Brown-out scope wrong.");

   property p_por_all;
      @(posedge CLOCK) disable iff (!NRST)
      !PWRON_N |=> !SYS_RST_N && !BACKUP_RST_N;
   endproperty
   a_por_all: assert property (p_por_all) else $error("Power reset did not reset all.");

   property p_bak_supply;
      @(posedge CLOCK) disable iff (!NRST)
      !BAK_SUPPLY_OK |=> !BACKUP_RST_N;
   endproperty
   a_bak_supply: assert property (p_bak_supply) else $error("Backup reset released early.");

   property p_core_seq;
      @(posedge CLOCK) disable iff (!NRST)
      $rose(CORE_PWR_OK) |=> !CORE_RST_N [*8];
   endproperty
   a_core_seq: assert property (p_core_seq) else $error("Core reset sequence too short.");

   property p_rtc_wake;
      @(posedge CLOCK) disable iff (!NRST)
      (pm_q != smpd_pkg::PM_RUN && RTC_MATCH && bd_q[smpd_pkg::BD_WKEN]) |=>
         WAKEUP ##1 PM_MODE == smpd_pkg::PM_RUN;
   endproperty
   a_rtc_wake: assert property (p_rtc_wake) else $error("Time match did not wake.");

   property p_stby_ldo;
      @(posedge CLOCK) disable iff (!NRST)
      (pm_q == smpd_pkg::PM_STBY) |=> REG_MODE == smpd_pkg::REG_OFF;
   endproperty
   a_stby_ldo: assert property (p_stby_ldo) else $error("Regulator not off in standby.");

   property p_entry;
      @(posedge CLOCK) disable iff (!NRST)
      (pm_q == smpd_pkg::PM_RUN && sleep_cmd && !ctl_q[smpd_pkg::CTL_SLPDEEP]) |=>
         pm_q == smpd_pkg::PM_SLEEP;
   endproperty
   a_entry: assert property (p_entry) else $error("Sleep not entered.");
endmodule

// [testbench/smpd_far_model.sv]
`timescale 1ns/1ps
module smpd_far_model (
   input  wire logic       clk,
   input  wire logic       rst_n,
   input  wire logic [1:0] cmd,
   input  wire logic [1:0] line,
   output logic            wait_irq,
   output logic            wait_evt,
   output logic      [1:0] pend
);
   logic [1:0] line_q;

   // The core only sleeps when told to, after the mode bits are set.
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         wait_irq <= 1'b0;
         wait_evt <= 1'b0;
      end else begin
         wait_irq <= cmd[0];
         wait_evt <= cmd[1];
      end
   end

   // Lines are set for rising edges only, so a glitch-free level is required.
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         line_q <= 2'h0;
         pend   <= 2'h0;
      end else begin
         line_q <= line;
         pend   <= pend | (line & ~line_q);
      end
   end
endmodule

// [testbench/test_supply_monitor_power_domain_ctrl.sv]
`timescale 1ns/1ps
module test_supply_monitor_power_domain_ctrl;
   typedef struct {
      string       nm;
      logic [31:0] ex;
   } smpd_note_s;
   logic        clk = 1'b0;
   logic        rst_n = 1'b0;
   logic        hsel = 1'b0;
   logic [1:0]  htrans = 2'h0;
   logic [7:0]  haddr = 8'h00;
   logic        hwrite = 1'b0;
   logic [2:0]  hsize = 3'h2;
   logic [31:0] hwdata = 32'h0;
   logic [1:0]  cmp = 2'h0;
   logic [2:0]  pwr = 3'h7;
   logic        core_ok = 1'b1;
   logic [2:0]  osc = 3'h0;
   logic        rtc_match = 1'b0;
   logic [1:0]  cmd = 2'h0;
   wire  [31:0] hrdata;
   wire         hready, hresp, bak_rst_n, sys_rst_n, core_rst_n, rtc_clk, wake, irq;
   wire  [2:0]  low_th;
   wire  [1:0]  over_th, ana_en, ev, slp, pm_mode, core_voltage_regulator, pend;
   smpd_note_s  notes [$];
   smpd_note_s  nt;
   logic [31:0] seen, v, rv;
   int          tick = 0;
   int          tock = 0;
   int          fail_count = 0;
   int          n_checks = 0;
   int          i, n;
   logic        prev;
   logic [31:0] cfg [4] = '{32'h0, 32'h400, 32'h600, 32'h500};
   logic [1:0]  pmx [4] = '{2'b01, 2'b11, 2'b11, 2'b10};
   logic [1:0]  ldx [4] = '{2'h0, 2'h0, 2'h1, 2'h2};
   logic [2:0]  pcase [3] = '{3'b101, 3'b110, 3'b011};
   logic [1:0]  rexp [3] = '{2'b10, 2'b01, 2'b00};

   smpd_top dut (.CLOCK(clk), .NRST(rst_n), .HSEL(hsel), .HTRANS(htrans), .HADDR(haddr),
      .HWRITE(hwrite), .HSIZE(hsize), .HWDATA(hwdata), .HREADY(hready), .HRDATA(hrdata),
      .HREADYOUT(hready), .HRESP(hresp), .LOWV_CMP(cmp[0]), .OVERV_CMP(cmp[1]),
      .LOWV_THRESH(low_th), .OVERV_THRESH(over_th), .LOWV_ANALOG_EN(ana_en[0]),
      .OVERV_ANALOG_EN(ana_en[1]), .EVT_LINE16(ev[0]), .EVT_LINE24(ev[1]),
      .PWRON_N(pwr[2]), .BROWN_N(pwr[1]), .BAK_SUPPLY_OK(pwr[0]), .CORE_PWR_OK(core_ok),
      .BACKUP_RST_N(bak_rst_n), .SYS_RST_N(sys_rst_n), .CORE_RST_N(core_rst_n),
      .SLOWRC_CLK(osc[0]), .LSXT_CLK(osc[1]), .HSXT_CLK(osc[2]), .RTC_CLK(rtc_clk),
      .RTC_MATCH(rtc_match), .WAIT_IRQ(slp[0]), .WAIT_EVT(slp[1]), .PM_MODE(pm_mode),
      .REG_MODE(core_voltage_regulator), .WAKEUP(wake), .IRQ(irq));
   smpd_far_model far (.clk(clk), .rst_n(rst_n), .cmd(cmd), .line(ev), .wait_irq(slp[0]),
      .wait_evt(slp[1]), .pend(pend));

   always #2 clk = ~clk;
   always @(posedge clk) osc[2] <= ~osc[2];

   task automatic print_verdict();
      if (fail_count == 0 && n_checks > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask

   task automatic chk(string nm, logic [31:0] sn, logic [31:0] ex);
      n_checks++;
      if (sn !== ex) begin
         fail_count++;
         $display("MISMATCH %s expected %h seen %h", nm, ex, sn);
      end
   endtask

   always @(posedge clk) begin
      if (tick != tock) begin
         tock = tick;
         nt = notes.pop_front();
         chk(nt.nm, seen, nt.ex);
      end
   end

   task automatic post(string nm, logic [31:0] sn, logic [31:0] ex);
      notes.push_back('{nm, ex});
      seen <= sn;
      tick <= tick + 1;
      @(posedge clk);
   endtask

   function automatic logic [31:0] pick(int s);
      case (s)
         0: return 32'(ev);
         1: return 32'({bak_rst_n, sys_rst_n});
         2: return 32'(pm_mode);
         3: return 32'(core_voltage_regulator);
         4: return 32'({irq, wake});
         5: return 32'({ana_en, over_th, low_th});
         6: return 32'(rtc_clk);
         7: return 32'({hresp, pend});
         default: return 32'(core_rst_n);
      endcase
   endfunction

   task automatic want(string nm, int s, logic [31:0] ex, int lim);
      int k;
      for (k = 0; k < lim; k++) begin
         @(posedge clk);
         if (pick(s) === ex) break;
      end
      post(nm, pick(s), ex);
   endtask

   // The slave answers at once, but the master still waits on ready, bounded.
   task automatic rdy();
      int k;
      for (k = 0; k < 16; k++) begin
         @(posedge clk);
         if (hready === 1'b1) break;
      end
      if (k == 16) begin
         fail_count++;
         print_verdict();
      end
   endtask

   task automatic xfer(logic w, logic [7:0] a, logic [31:0] d, output logic [31:0] r);
      hsel <= 1'b1;
      htrans <= smpd_pkg::HTRANS_NONSEQ;
      haddr <= a;
      hwrite <= w;
      rdy();
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= d;
      rdy();
      r = hrdata;
   endtask

   task automatic wr(logic [7:0] a, logic [31:0] d);
      logic [31:0] r;
      xfer(1'b1, a, d, r);
   endtask

   task automatic rd(string nm, logic [7:0] a, logic [31:0] ex);
      logic [31:0] r;
      xfer(1'b0, a, 32'h0, r);
      post(nm, r, ex);
   endtask

   task automatic sleep(logic e);
      cmd <= e ? 2'b10 : 2'b01;
      @(posedge clk);
      cmd <= 2'b00;
   endtask

   task automatic match();
      rtc_match <= 1'b1;
      @(posedge clk);
      rtc_match <= 1'b0;
   endtask

   initial begin
      rv = $urandom(32'h565b5bb4);
      repeat (8) @(posedge clk);
      rst_n <= 1'b1;
      want("rst_out", 1, 32'h3, 40);
      want("core_on", 8, 32'h1, 40);
      want("pm_rst", 2, 32'h0, 1);
      want("ldo_rst", 3, 32'(smpd_pkg::REG_FULL), 1);
      want("resp", 7, 32'h0, 1);
      rd("ctl_rst", smpd_pkg::OFF_CTL, smpd_pkg::CTL_RST);
      rd("bd_rst", smpd_pkg::OFF_BDCTL, smpd_pkg::BDCTL_RST);
      rd("cs_rst", smpd_pkg::OFF_CS, 32'h0);
      wr(8'h40, 32'hffff_ffff);
      rd("unmapped", 8'h40, 32'h0);
      repeat (4) begin
         v = $urandom() & 32'h0000_07f7;
         wr(smpd_pkg::OFF_CTL, v);
         rd("ctl_rw", smpd_pkg::OFF_CTL, v);
         want("thresh", 5, 32'({v[7], v[4], v[6:5], v[2:0]}), 4);
      end
      for (i = 0; i < 2; i++) begin
         wr(smpd_pkg::OFF_CTL, 32'h0);
         wr(smpd_pkg::OFF_INT_EN, 32'h7);
         cmp[i] <= 1'b1;
         repeat (6) @(posedge clk);
         want("ev_off", 0, 32'h0, 1);
         rd("flag_off", smpd_pkg::OFF_CS, 32'h0);
         wr(smpd_pkg::OFF_CTL, 32'h1 << (i ? smpd_pkg::CTL_OVEN : smpd_pkg::CTL_LVEN));
         want("ev_on", 0, 32'h1 << i, 6);
         rd("flag_on", smpd_pkg::OFF_CS, 32'h1 << i);
         rd("st_on", smpd_pkg::OFF_INT_ST, 32'h1 << i);
         want("irq_on", 4, 32'h2, 4);
         want("pend", 7, 32'(2 * i + 1), 2);
         wr(smpd_pkg::OFF_INT_EN, 32'h0);
         want("irq_mask", 4, 32'h0, 4);
         wr(smpd_pkg::OFF_INT_CLR, 32'h1 << i);
         rd("st_clr", smpd_pkg::OFF_INT_ST, 32'h0);
         cmp[i] <= 1'b0;
         want("ev_low", 0, 32'h0, 6);
         rd("flag_low", smpd_pkg::OFF_CS, 32'h0);
         wr(smpd_pkg::OFF_INT_CLR, 32'h7);
      end
      wr(smpd_pkg::OFF_BDCTL, 32'hc | 32'(smpd_pkg::RTC_SLOWRC));
      for (i = 0; i < 4; i++) begin
         wr(smpd_pkg::OFF_CTL, cfg[i]);
         sleep(i[0]);
         want("pm", 2, 32'(pmx[i]), 6);
         want("ldo", 3, 32'(ldx[i]), 6);
         match();
         want("wake", 4, 32'h1, 8);
         want("pm_run", 2, 32'h0, 8);
      end
      rd("stbf", smpd_pkg::OFF_CS, 32'h1 << smpd_pkg::CS_STBF);
      wr(smpd_pkg::OFF_BDCTL, 32'h4 | 32'(smpd_pkg::RTC_SLOWRC));
      wr(smpd_pkg::OFF_CTL, 32'h0);
      sleep(1'b0);
      match();
      repeat (8) @(posedge clk);
      want("no_wake", 2, 32'h1, 1);
      wr(smpd_pkg::OFF_BDCTL, 32'hc | 32'(smpd_pkg::RTC_SLOWRC));
      match();
      want("pm_wk", 2, 32'h0, 8);
      rd("st_wake", smpd_pkg::OFF_INT_ST, 32'h1 << smpd_pkg::IRQ_WAKE);
      for (i = 1; i < 3; i++) begin
         wr(smpd_pkg::OFF_BDCTL, 32'h4 | 32'(i));
         osc[1:0] <= 2'b01;
         want("rtc_a", 6, 32'(i == 1), 6);
         osc[1:0] <= 2'b10;
         want("rtc_b", 6, 32'(i == 2), 6);
      end
      wr(smpd_pkg::OFF_BDCTL, 32'h4 | 32'(smpd_pkg::RTC_HXT128));
      n = 0;
      prev = 1'b1;
      repeat (8 * smpd_pkg::HXT_DIV) begin
         @(posedge clk);
         n += int'(rtc_clk === 1'b1 && prev === 1'b0);
         prev = rtc_clk;
      end
      post("rtc_div", 32'(n >= 3 && n <= 5), 32'h1);
      wr(smpd_pkg::OFF_BDCTL, 32'h1 << smpd_pkg::BD_SWRST);
      want("bk_sw", 1, 32'h1, 6);
      wr(smpd_pkg::OFF_BDCTL, 32'h0);
      want("bk_rel", 1, 32'h3, 6);
      for (i = 0; i < 3; i++) begin
         pwr <= pcase[i];
         want("rst_lvl", 1, 32'(rexp[i]), 8);
         pwr <= 3'h7;
         want("rst_rel", 1, 32'h3, 40);
      end
      core_ok <= 1'b0;
      want("core_off", 8, 32'h0, 8);
      core_ok <= 1'b1;
      n = 0;
      while (core_rst_n !== 1'b1 && n < 64) begin
         @(posedge clk);
         n++;
      end
      v = 32'(n >= smpd_pkg::CORE_RST_CYC && n <= smpd_pkg::CORE_RST_CYC + 6);
      post("core_seq", v, 32'h1);
      // Let the compare process take the last note before the verdict.
      repeat (2) @(posedge clk);
      print_verdict();
   end
endmodule
